/* File: verilog/fgw_defines.svh */
// constants for the floppy group-code write path
// assumes a 50 MHz CLK and a 20-bit host address bus
// Functional notes
// R1: each 8-bit host byte becomes a 10-bit group code shifted onto the media.
// R2: host writes each byte into the port B output register at E80E0.
// R3: port selected only for the full address pattern with memory cycle.
// R4: host programs port B direction to all outputs before writing data.
// R5: direction low passes host data and bit clock into the encoder path.
// R6: data bits form ROM address 0..8 except bit 4 (sync); bit 9 high.
// R7: direction drives ROM address bit 10; low selects the encode table.
// R8: serializer word is eight ROM outputs plus address bits 2 and 7.
// R9: bit clock comes from a counter stepped every base clock; 1 us period.
// R10: bit clock counter cleared at power-up, then runs continuously.
// R11: shift on inverted bit clock; serial bit NANDed with bit clock.
// R12: each rising pulse edge toggles the write flip-flop, one flux reversal.
// R13: write protect or read direction holds both write phases high.
// R14: low positive phase drives current one way, low negative the other.
// R15: head A0 select goes low when side and drive selects are low.
// R16: host requests sync by raising sync request and setting bits 2 and 6.
// R17: sync code is ten ones through the same write path as data.
// R18: controller puts sync codes before sector headers and data blocks.
// R19: four head selects map A0, A1, B0, B1; low selects the head.
// R20: serializer reloads every ten bit periods; host supplies byte before.
`ifndef FGW_DEFINES_SVH
`define FGW_DEFINES_SVH

`define FGW_CLK_PERIOD_NS 20
`define FGW_BIT_PERIOD_NS 1000
`define FGW_GROUP_BITS 10
`define FGW_DATA_BITS 8
`define FGW_FIFO_DEPTH 4

// address pattern fields of the write port select
`define FGW_ADDR_HI_PATTERN 3'h7
`define FGW_ADDR_MID_PATTERN 3'h7
`define FGW_REG_OUTPUT_IDX 4'h0
`define FGW_REG_DIR_IDX 4'h2
`define FGW_PORT_OUTPUT_ADDR 20'hE80E0
`define FGW_PORT_DIR_ADDR 20'hE80E2

`define FGW_DIR_RESET 8'h00
`define FGW_OUT_RESET 8'h00
`define FGW_ROM_SYNC_CODE 8'hFF
`define FGW_ROM_READ_FILL 8'h00

`endif

/* File: verilog/fgw_pkg.sv */
// types shared by the floppy write path
// assumes fgw_defines.svh for the numeric constants
package fgw_pkg;
  typedef enum logic [0:0] {
    FGW_SER_IDLE,
    FGW_SER_RUN
  } fgw_ser_e;
  typedef logic [9:0] fgw_code_t;
  typedef logic [8:0] fgw_entry_t;
endpackage

/* File: verilog/fgw_fifo.sv */
// small byte fifo between the host port and the serializer
// assumes single clock, async active-high reset
`timescale 1ns/1ps
module fgw_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_cfg
    $error("fgw_fifo: depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  // full and empty both come from the occupancy count
  assign in_ready = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_q];

  // storage has no reset; only valid entries are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + AW'(1);
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + AW'(1);
      end
      if (push && !pop) begin
        count_q <= count_q + (AW+1)'(1);
      end else if (pop && !push) begin
        count_q <= count_q - (AW+1)'(1);
      end
    end
  end
endmodule

/* File: verilog/fgw_write_path.sv */
// floppy write path: host port, group-code translation, serializer,
// write flip-flop and head select decode
// assumes host bus strobes are synchronous to CLK; drive-side levels are not
`timescale 1ns/1ps
`include "fgw_defines.svh"
module fgw_write_path #(
  parameter int FIFO_DEPTH = `FGW_FIFO_DEPTH
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [19:0] BUS_ADDR,
  input wire logic BUS_IO_NOT_MEM,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  input wire logic [7:0] BUS_WDATA,
  output logic [7:0] BUS_RDATA,
  output logic WRITE_PORT_READY,
  input wire logic SYNC_CODE_REQUEST,
  input wire logic READ_NOT_WRITE_DIR,
  input wire logic WRITE_PROTECT_SENSE,
  input wire logic SIDE_SELECT,
  input wire logic DRIVE_SELECT,
  output logic WRITE_BIT_CLOCK,
  output logic ENCODED_WRITE_PULSES,
  output logic WRITE_PHASE_POS_N,
  output logic WRITE_PHASE_NEG_N,
  output logic HEAD_SELECT_A0_N,
  output logic HEAD_SELECT_A1_N,
  output logic HEAD_SELECT_B0_N,
  output logic HEAD_SELECT_B1_N
);
  localparam int BIT_CYC = `FGW_BIT_PERIOD_NS / `FGW_CLK_PERIOD_NS;
  localparam int HALF_CYC = BIT_CYC / 2;
  localparam int NPIN = 5;

  // the divider is six bits wide, so longer bit periods cannot be served
  if (BIT_CYC < 2 || BIT_CYC > 63 || FIFO_DEPTH < 2) begin : g_bad_cfg
    $error("fgw_write_path: bit period or fifo depth out of range");
  end

  // two-stage synchronisers for the drive-side levels
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_q;
  logic [NPIN-1:0] pin_s2_q;
  assign pin_raw = {DRIVE_SELECT, SIDE_SELECT, WRITE_PROTECT_SENSE,
                    READ_NOT_WRITE_DIR, SYNC_CODE_REQUEST};
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
          pin_s1_q[gi] <= 1'b0;
          pin_s2_q[gi] <= 1'b0;
        end else begin
          pin_s1_q[gi] <= pin_raw[gi];
          pin_s2_q[gi] <= pin_s1_q[gi];
        end
      end
    end
  endgenerate

  logic sync_req_s;
  logic rnw_s;
  logic wps_s;
  logic side_s;
  logic drive_s;
  assign sync_req_s = pin_s2_q[0];
  assign rnw_s = pin_s2_q[1];
  assign wps_s = pin_s2_q[2];
  assign side_s = pin_s2_q[3];
  assign drive_s = pin_s2_q[4];

  // write port select decode over the full address pattern
  logic port_sel;
  logic [3:0] reg_idx;
  assign port_sel = (BUS_ADDR[19:17] == `FGW_ADDR_HI_PATTERN) && !BUS_ADDR[16] &&
                    BUS_ADDR[15] && !BUS_ADDR[8] &&
                    (BUS_ADDR[7:5] == `FGW_ADDR_MID_PATTERN) &&
                    !BUS_IO_NOT_MEM; // see R3
  assign reg_idx = BUS_ADDR[3:0];

  logic [7:0] out_reg_q;
  logic [7:0] dir_reg_q;
  logic wr_out;
  logic wr_dir;
  always_comb begin
    wr_out = 1'b0;
    wr_dir = 1'b0;
    if (port_sel && BUS_WR && reg_idx == `FGW_REG_OUTPUT_IDX) begin
      wr_out = 1'b1; // see R2
    end else if (port_sel && BUS_WR && reg_idx == `FGW_REG_DIR_IDX) begin
      wr_dir = 1'b1;
    end
  end

  // port registers; pins not set as outputs float high at the encoder
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      out_reg_q <= `FGW_OUT_RESET;
      dir_reg_q <= `FGW_DIR_RESET;
    end else begin
      if (wr_out) begin
        out_reg_q <= BUS_WDATA;
      end
      if (wr_dir) begin
        dir_reg_q <= BUS_WDATA; // see R4
      end
    end
  end

  // read answer one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      BUS_RDATA <= 8'h00;
    end else if (port_sel && BUS_RD && reg_idx == `FGW_REG_OUTPUT_IDX) begin
      BUS_RDATA <= out_reg_q;
    end else if (port_sel && BUS_RD && reg_idx == `FGW_REG_DIR_IDX) begin
      BUS_RDATA <= dir_reg_q;
    end else begin
      BUS_RDATA <= 8'h00;
    end
  end

  // each accepted byte is queued with the sync request level beside it
  logic [7:0] pin_byte;
  fgw_pkg::fgw_entry_t fifo_in;
  fgw_pkg::fgw_entry_t fifo_out;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  assign pin_byte = (BUS_WDATA & dir_reg_q) | ~dir_reg_q;
  assign fifo_in = {sync_req_s, pin_byte};

  fgw_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(CLK),
    .reset(RESET),
    .in_valid(wr_out),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      WRITE_PORT_READY <= 1'b0;
    end else begin
      WRITE_PORT_READY <= fifo_in_ready;
    end
  end

  // free-running bit clock divider, cleared only by reset
  logic [5:0] bit_cnt_q;
  logic [5:0] bit_cnt_d;
  logic bit_fall;
  assign bit_fall = (bit_cnt_q == 6'(BIT_CYC - 1));
  assign bit_cnt_d = bit_fall ? 6'h00 : bit_cnt_q + 6'h01; // see R9
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      bit_cnt_q <= 6'h00; // see R10
      WRITE_BIT_CLOCK <= 1'b0;
    end else begin
      bit_cnt_q <= bit_cnt_d;
      WRITE_BIT_CLOCK <= (bit_cnt_d >= 6'(HALF_CYC));
    end
  end

  // translation table; lower half encodes, upper half belongs to reading
  function automatic logic [7:0] rom_lookup(input logic [10:0] a);
    logic [7:0] code;
    code = {a[8], a[6], a[5], a[3], ~a[1], a[1], ~a[0], a[0]};
    if (a[10]) begin
      code = `FGW_ROM_READ_FILL;
    end else if (a[9] && a[4] && a[2] && a[7]) begin
      code = `FGW_ROM_SYNC_CODE; // see R17
    end
    return code;
  endfunction

  // rom address from queued byte, sync bit and direction
  logic [10:0] rom_address_bus;
  logic [7:0] rom_code_out;
  fgw_pkg::fgw_code_t load_word;
  assign rom_address_bus = {rnw_s, 1'b1, fifo_out[7:4], fifo_out[8],
                            fifo_out[3:0]}; // see R6 // see R7
  assign rom_code_out = rom_lookup(rom_address_bus);
  assign load_word = {rom_code_out, rom_address_bus[7],
                      rom_address_bus[2]}; // see R8

  // serializer: starts on the first queued byte, then repeats every ten bits
  fgw_pkg::fgw_ser_e ser_state_q;
  fgw_pkg::fgw_code_t shreg_q;
  fgw_pkg::fgw_code_t last_word_q;
  logic [3:0] bit_idx_q;
  logic group_end;
  logic load;
  assign group_end = (ser_state_q == fgw_pkg::FGW_SER_IDLE) ||
                     (bit_idx_q == 4'(`FGW_GROUP_BITS - 1));
  assign load = bit_fall && group_end; // see R20
  assign fifo_pop = load && fifo_out_valid && !rnw_s; // see R5

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ser_state_q <= fgw_pkg::FGW_SER_IDLE;
      shreg_q <= '0;
      last_word_q <= '0;
      bit_idx_q <= 4'h0;
    end else begin
      case (ser_state_q)
        fgw_pkg::FGW_SER_IDLE: begin
          if (fifo_pop) begin
            shreg_q <= load_word; // see R1
            last_word_q <= load_word;
            bit_idx_q <= 4'h0;
            ser_state_q <= fgw_pkg::FGW_SER_RUN;
          end
        end
        fgw_pkg::FGW_SER_RUN: begin
          if (bit_fall) begin
            if (group_end) begin
              // a late host byte repeats the previous group rather than gap
              shreg_q <= fifo_pop ? load_word : last_word_q; // see R20
              if (fifo_pop) begin
                last_word_q <= load_word;
              end
              bit_idx_q <= 4'h0;
            end else begin
              shreg_q <= {shreg_q[8:0], 1'b0}; // see R11
              bit_idx_q <= bit_idx_q + 4'h1;
            end
          end
        end
        default: begin
          ser_state_q <= fgw_pkg::FGW_SER_IDLE;
        end
      endcase
    end
  end

  // nand of serial bit with bit clock forms the pulse train
  logic serial_bit;
  logic wclk_now;
  assign serial_bit = (ser_state_q == fgw_pkg::FGW_SER_RUN) && shreg_q[9];
  assign wclk_now = (bit_cnt_q >= 6'(HALF_CYC));
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ENCODED_WRITE_PULSES <= 1'b1;
    end else begin
      ENCODED_WRITE_PULSES <= !(serial_bit && wclk_now); // see R11
    end
  end

  // write flip-flop; its rising pulse edge is the bit clock falling edge
  logic write_en;
  logic tog_q;
  logic tog_d;
  logic tog_ev;
  assign write_en = !wps_s && !rnw_s;
  assign tog_ev = write_en && bit_fall && serial_bit;
  always_comb begin
    tog_d = tog_q;
    if (!write_en) begin
      tog_d = 1'b0; // see R13
    end else if (tog_ev) begin
      tog_d = !tog_q; // see R12
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      tog_q <= 1'b0;
      WRITE_PHASE_POS_N <= 1'b1;
      WRITE_PHASE_NEG_N <= 1'b1;
    end else begin
      tog_q <= tog_d;
      WRITE_PHASE_POS_N <= !write_en || tog_d; // see R14
      WRITE_PHASE_NEG_N <= !write_en || !tog_d; // see R13
    end
  end

  // head select decode: side picks head, drive picks A or B
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      HEAD_SELECT_A0_N <= 1'b1;
      HEAD_SELECT_A1_N <= 1'b1;
      HEAD_SELECT_B0_N <= 1'b1;
      HEAD_SELECT_B1_N <= 1'b1;
    end else begin
      HEAD_SELECT_A0_N <= !(!drive_s && !side_s); // see R15
      HEAD_SELECT_A1_N <= !(!drive_s && side_s); // see R19
      HEAD_SELECT_B0_N <= !(drive_s && !side_s);
      HEAD_SELECT_B1_N <= !(drive_s && side_s);
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  AST_BITCLK_PERIOD: assert property ( // see R9
    $rose(WRITE_BIT_CLOCK) |-> ##50 $rose(WRITE_BIT_CLOCK)
  ) else $error("bit clock period is not 50 cycles");

  AST_BITCLK_HIGH: assert property ( // see R10
    $rose(WRITE_BIT_CLOCK) |-> WRITE_BIT_CLOCK [*8]
  ) else $error("bit clock high phase too short");

  AST_INHIBIT: assert property ( // see R13
    (wps_s || rnw_s) |=> (WRITE_PHASE_POS_N && WRITE_PHASE_NEG_N)
  ) else $error("write phase active while inhibited");

  AST_PHASE_EXCL: assert property ( // see R14
    !WRITE_PHASE_POS_N |-> WRITE_PHASE_NEG_N
  ) else $error("both write phases low");

  AST_TOGGLE: assert property ( // see R12
    (tog_ev && $past(write_en)) |=> (WRITE_PHASE_POS_N != $past(WRITE_PHASE_POS_N))
  ) else $error("write flip-flop did not toggle");

  AST_HEAD_A0: assert property ( // see R15
    (!side_s && !drive_s) |=> !HEAD_SELECT_A0_N && HEAD_SELECT_A1_N
  ) else $error("head A0 select wrong");

  AST_ONE_HEAD: assert property ( // see R19
    $onehot({!HEAD_SELECT_A0_N, !HEAD_SELECT_A1_N, !HEAD_SELECT_B0_N,
             !HEAD_SELECT_B1_N}) || $past(RESET)
  ) else $error("head selects not one-hot");

  AST_NO_EARLY_LOAD: assert property ( // see R20
    (bit_fall && ser_state_q == fgw_pkg::FGW_SER_RUN && bit_idx_q != 4'h9) |-> !fifo_pop
  ) else $error("group reloaded before ten bits");

  AST_SYNC_ONES: assert property ( // see R17
    (fifo_pop && fifo_out[8] && fifo_out[2] && fifo_out[6]) |=> (shreg_q == 10'h3FF)
  ) else $error("sync code not all ones");

  AST_DECODE: assert property ( // see R3
    (BUS_WR && BUS_ADDR[8]) |=> (out_reg_q == $past(out_reg_q))
  ) else $error("write accepted outside port decode");

  AST_PULSE_LOW: assert property ( // see R11
    (!ENCODED_WRITE_PULSES) |-> $past(shreg_q[9]) && $past(wclk_now)
  ) else $error("pulse without serial one and bit clock");
endmodule

/* File: tb/fgw_media_model.sv */
// head driver stand-in: counts flux reversals and rebuilds the bit stream
// assumes phases settle within one cycle after the bit clock falls
`timescale 1ns/1ps
module fgw_media_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic bit_clock,
  input wire logic pos_n,
  input wire logic neg_n,
  output int flips,
  output logic [63:0] hist,
  output logic both_low
);
  logic pos_q;
  logic clk_q;
  logic flip_q;
  logic flip;
  // a reversal is a swap of the low phase while enabled
  assign flip = (pos_n != pos_q) && (pos_n != neg_n);
  // bits are collected at mid-period, after the toggle of the bit before
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pos_q <= 1'b1;
      clk_q <= 1'b0;
      flip_q <= 1'b0;
      flips <= 0;
      hist <= 64'h0;
      both_low <= 1'b0;
    end else begin
      pos_q <= pos_n;
      clk_q <= bit_clock;
      if (flip) begin
        flips <= flips + 1;
      end
      if (bit_clock && !clk_q) begin
        hist <= {hist[62:0], flip_q | flip};
        flip_q <= 1'b0;
      end else if (flip) begin
        flip_q <= 1'b1;
      end
      // current both ways at once would be a driver fault
      if (!pos_n && !neg_n) begin
        both_low <= 1'b1;
      end
    end
  end
endmodule

/* File: tb/test_fgw_write_path.sv */
// self-checking bench for the floppy write path
// assumes the media model beside it and a 50 MHz clock
`timescale 1ns/1ps
module test_fgw_write_path;
  logic CLK, RESET, IO, WR, RD, SYNC, RDIR, WP, SIDE, DRV;
  logic [19:0] ADDR;
  logic [7:0] WDATA, RDATA;
  logic READY, BCLK, PULSES, POS_N, NEG_N, A0, A1, B0, B1;
  int flips, mismatches, n_checks, cycles;
  logic [63:0] hist;
  logic both_low;
  fgw_write_path uut (.CLK(CLK), .RESET(RESET), .BUS_ADDR(ADDR), .BUS_IO_NOT_MEM(IO),
    .BUS_WR(WR), .BUS_RD(RD), .BUS_WDATA(WDATA), .BUS_RDATA(RDATA),
    .WRITE_PORT_READY(READY), .SYNC_CODE_REQUEST(SYNC), .READ_NOT_WRITE_DIR(RDIR),
    .WRITE_PROTECT_SENSE(WP), .SIDE_SELECT(SIDE), .DRIVE_SELECT(DRV),
    .WRITE_BIT_CLOCK(BCLK), .ENCODED_WRITE_PULSES(PULSES), .WRITE_PHASE_POS_N(POS_N),
    .WRITE_PHASE_NEG_N(NEG_N), .HEAD_SELECT_A0_N(A0), .HEAD_SELECT_A1_N(A1),
    .HEAD_SELECT_B0_N(B0), .HEAD_SELECT_B1_N(B1));
  fgw_media_model media (.clk(CLK), .reset(RESET), .bit_clock(BCLK), .pos_n(POS_N),
    .neg_n(NEG_N), .flips(flips), .hist(hist), .both_low(both_low));
  // 20 ns clock
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // one-cycle write strobe, released after the sampling edge
  task automatic bus_write(logic [19:0] a, logic [7:0] d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
    WDATA <= ~d;
  endtask
  task automatic bus_read(logic [19:0] a, logic io, logic [7:0] exp);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    IO <= io;
    @(posedge CLK);
    RD <= 1'b0;
    IO <= 1'b0;
    #1 chk(RDATA, exp);
  endtask
  // first zero below the newest run of ones, with its run length
  function automatic logic [7:0] tail_of(logic [63:0] h);
    int i;
    i = 0;
    while (i < 62 && h[i]) i++;
    return {i[5:0], h[i+1], h[i]};
  endfunction
  // hang guard: the sequence needs about 19000 cycles
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      report_and_stop;
    end
  end
  initial begin
    logic [7:0] b, t;
    int hi, ri, f0, pf;
    logic pv;
    {RESET, IO, WR, RD, SYNC, RDIR, WP, SIDE, DRV} = 9'h100;
    ADDR = 20'h0;
    WDATA = 8'h00;
    mismatches = 0;
    n_checks = 0;
    cycles = 0;
    void'($urandom(29));
    repeat (2) @(posedge CLK);
    #1 chk({RDATA, READY, BCLK, PULSES, POS_N, NEG_N, A0, A1, B0, B1}, 17'h0007F);
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    repeat (4) @(posedge CLK);
    // ten bit periods fit exactly in 500 cycles, half of them high
    hi = 0;
    ri = 0;
    pv = BCLK;
    repeat (500) begin
      @(posedge CLK);
      hi += BCLK;
      ri += (BCLK && !pv);
      pv = BCLK;
    end
    chk(hi, 250);
    chk(ri, 10);
    // every side and drive pairing lights one head
    for (int k = 0; k < 4; k++) begin
      @(posedge CLK);
      {DRV, SIDE} <= 2'(k);
      repeat (5) @(posedge CLK);
      chk({B1, B0, A1, A0}, ~(4'h1 << k) & 4'hF);
    end
    bus_write(20'hE80E2, 8'hFF);
    bus_read(20'hE80E2, 1'b0, 8'hFF);
    bus_read(20'hE80E2, 1'b1, 8'h00);
    bus_read(20'hE81E2, 1'b0, 8'h00);
    bus_read(20'hE80C2, 1'b0, 8'h00);
    // sync, random byte, sync: the byte's tail bits sit before the run
    for (int n = 0; n < 5; n++) begin
      b = (n == 0) ? 8'h40 : 8'($urandom);
      b[2] = 1'b0;
      SYNC <= 1'b1;
      repeat (4) @(posedge CLK);
      bus_write(20'hE80E0, 8'h44);
      SYNC <= 1'b0;
      repeat (4) @(posedge CLK);
      bus_write(20'hE80E0, b);
      SYNC <= 1'b1;
      repeat (4) @(posedge CLK);
      bus_write(20'hE80E0, 8'h44);
      SYNC <= 1'b0;
      repeat (2800) @(posedge CLK);
      t = tail_of(hist);
      chk(t[0], 1'b0);
      chk(t[1], b[6]);
      chk(t[7:2] >= 6'd10, 1'b1);
    end
    // steady sync: one reversal and one pulse per bit
    f0 = flips;
    pf = 0;
    pv = PULSES;
    repeat (1000) begin
      @(posedge CLK);
      pf += (!PULSES && pv);
      pv = PULSES;
    end
    chk(flips - f0, 20);
    chk(pf, 20);
    chk({POS_N ^ NEG_N, both_low}, 2'b10);
    // write protect freezes both phases high
    WP <= 1'b1;
    repeat (5) @(posedge CLK);
    f0 = flips;
    repeat (600) @(posedge CLK);
    chk({POS_N, NEG_N, 30'(flips - f0)}, 32'hC0000000);
    WP <= 1'b0;
    RDIR <= 1'b1;
    repeat (5) @(posedge CLK);
    // read direction: no pops, so the first four of six writes fill the queue
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= 20'hE80E0;
    for (int n = 0; n < 6; n++) begin
      WDATA <= 8'($urandom);
      @(posedge CLK);
    end
    WR <= 1'b0;
    repeat (2) @(posedge CLK);
    chk({READY, POS_N, NEG_N}, 3'b011);
    RDIR <= 1'b0;
    repeat (2600) @(posedge CLK);
    chk(READY, 1'b1);
    report_and_stop;
  end
endmodule
